// File: hw/fan_ctrl_pkg.sv
// Purpose: Shared constants and helpers for the fan master control register bank.
// Assumes: Byte-wide register port, 20 MHz device clock.
// Notes: Every offset, bit position, reset value and timing count lives here.
package fan_ctrl_pkg;

  // Register offsets on the byte-wide register port.
  localparam logic [7:0] MASTER_CTRL_ADDR = 8'h40;
  localparam logic [7:0] CUR_DUTY_ADDR = 8'h30;
  localparam logic [7:0] PARAM_FIRST_ADDR = 8'h5C;
  localparam logic [7:0] PARAM_LAST_ADDR = 8'h6E;

  // Number of protected fan limit and parameter bytes, and the index width.
  localparam int PARAM_COUNT = 19;
  localparam int PARAM_IDX_W = 5;

  // Bit positions inside the master control register.
  localparam int START_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int READY_BIT = 2;
  localparam int FORCE_BIT = 3;

  // Reset value of the master control register and the duty extremes.
  localparam logic [7:0] MASTER_CTRL_RESET = 8'h00;
  localparam logic [7:0] FULL_DUTY = 8'hFF;
  localparam logic [7:0] OFF_DUTY = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Built-in defaults of the protected parameter bytes.
  localparam logic [4:0] FAN_CFG_IDX = 5'h00;
  localparam logic [4:0] RANGE1_IDX = 5'h03;
  localparam logic [4:0] RANGE2_IDX = 5'h04;
  localparam logic [7:0] FAN_CFG_DFLT = 8'h62;
  localparam logic [7:0] RANGE_DFLT = 8'hC3;
  localparam logic [7:0] PARAM_DFLT_OTHER = 8'h00;

  // Power-up settling time before the ready flag may rise, and its cycle count.
  localparam int CLK_HZ = 20_000_000;
  localparam int POR_TIME_NS = 10_000;
  localparam int POR_CYCLES = (POR_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int POR_CNT_W = 9;

  // Returns the built-in default of one protected parameter byte.
  function automatic logic [7:0] param_default(input logic [4:0] idx);
    if (idx == FAN_CFG_IDX) begin
      return FAN_CFG_DFLT;
    end else if (idx == RANGE1_IDX || idx == RANGE2_IDX) begin
      return RANGE_DFLT;
    end else begin
      return PARAM_DFLT_OTHER;
    end
  endfunction : param_default

  // Tells whether an address falls in the protected parameter window.
  function automatic logic in_param_range(input logic [7:0] addr);
    return (addr >= PARAM_FIRST_ADDR) && (addr <= PARAM_LAST_ADDR);
  endfunction : in_param_range

  // Converts a register address to its parameter byte index.
  function automatic logic [4:0] param_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - PARAM_FIRST_ADDR;
    return diff[4:0];
  endfunction : param_index

endpackage : fan_ctrl_pkg

// File: hw/level_sync3.sv
// Purpose: Brings an asynchronous level into the clock domain.
// Assumes: The input may change at any time relative to clk.
// Notes: The output follows only once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module level_sync3 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic asyncIn,
  output logic syncOut
);

  // All state of the synchroniser in one packed record.
  typedef struct packed {
    logic stage1;
    logic stage2;
    logic stage3;
    logic level;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  // Shifts the chain and accepts a change once stages two and three agree.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage1 = asyncIn;
    nxt_st.stage2 = st_ff.stage1;
    nxt_st.stage3 = st_ff.stage2;
    if (st_ff.stage2 == st_ff.stage3) begin
      nxt_st.level = st_ff.stage3;
    end
  end

  // Registers the state; reset clears every stage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // The settled level leaves straight from a flip-flop.
  assign syncOut = st_ff.level;

endmodule : level_sync3
`default_nettype wire

// File: hw/ready_timer.sv
// Purpose: Raises the ready flag after power-up settling and converter health.
// Assumes: adcOk is already in the clock domain.
// Notes: The flag is sticky until the next power-up reset.
`timescale 1ns/1ps
`default_nettype none
module ready_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic adcOk,
  output logic readyOut
);

  // All state of the timer in one packed record.
  typedef struct packed {
    logic [8:0] count;
    logic porDone;
    logic ready;
  } timer_state_t;

  timer_state_t st_ff;
  timer_state_t nxt_st;

  localparam logic [8:0] POR_LAST = 9'(fan_ctrl_pkg::POR_CYCLES - 1);

  // Counts out the settling time, then waits for healthy converters.
  always_comb begin
    nxt_st = st_ff;
    if (!st_ff.porDone) begin
      if (st_ff.count == POR_LAST) begin
        nxt_st.porDone = 1'b1;
      end else begin
        nxt_st.count = st_ff.count + 9'h001;
      end
    end
    if (st_ff.porDone && adcOk) begin
      nxt_st.ready = 1'b1;
    end
  end

  // Registers the state; reset restarts the settling time.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // The ready level leaves straight from a flip-flop.
  assign readyOut = st_ff.ready;

endmodule : ready_timer
`default_nettype wire

// File: hw/fan_ctrl_start_lock_override.sv
// Purpose: Master control register bank with start, lock, ready and full-duty override.
// Assumes: rst_n is the power-up reset; the register port is byte wide.
// Notes: The protected parameter bytes are held here so the lock can guard them.
// Functional notes
// - Start set selects programmed parameter values.
// - Before start, defaults stay in use.
// - Start clear always selects defaults.
// - Start changes never alter stored parameters.
// - Start stays writable while locked.
// - Lock makes parameter registers read-only.
// - Lock cannot be cleared by software.
// - Ready is read-only, set by hardware.
// - Override forces full duty on PWM.
// - Override beats a disabled PWM channel.
// - Locked parameter writes are discarded.
// - Before start, duty runs full, reads FF.
`timescale 1ns/1ps
`default_nettype none
module fan_ctrl_start_lock_override (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic adcOkAsync,
  input wire logic [4:0] paramSelIdx,
  output logic [7:0] paramSelData,
  input wire logic [7:0] autoDuty,
  input wire logic pwmDisabled,
  output logic [7:0] dutyOut,
  output logic startActive,
  output logic lockActive,
  output logic forceFullDuty
);

  // All state of the bank in one packed record.
  typedef struct packed {
    logic startFlag;
    logic lockFlag;
    logic forceFlag;
    logic [fan_ctrl_pkg::PARAM_COUNT-1:0][7:0] progRegs;
    logic [7:0] rdData;
    logic rdValid;
    logic [7:0] duty;
    logic [7:0] selData;
  } ctrl_state_t;

  ctrl_state_t st_ff;
  ctrl_state_t nxt_st;

  // Converter health after the three-stage synchroniser.
  logic adcOk;
  // Sticky ready level from the power-up timer.
  logic readyFlag;
  // Decoded write strobes.
  logic ctrlWr;
  logic paramWr;
  // Index of the addressed parameter byte.
  logic [4:0] wrIdx;

  // Synchronises the converter health level from the analog side.
  level_sync3 u_adc_sync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(adcOkAsync),
    .syncOut(adcOk)
  );

  // Times the power-up settling and raises ready.
  ready_timer u_ready (
    .clk(clk),
    .rst_n(rst_n),
    .adcOk(adcOk),
    .readyOut(readyFlag)
  );

  // Decodes the register port address.
  always_comb begin
    ctrlWr = 1'b0;
    paramWr = 1'b0;
    wrIdx = fan_ctrl_pkg::param_index(regAddr);
    if (regWrEn && regAddr == fan_ctrl_pkg::MASTER_CTRL_ADDR) begin
      ctrlWr = 1'b1;
    end else if (regWrEn && fan_ctrl_pkg::in_param_range(regAddr)) begin
      paramWr = 1'b1;
    end
  end

  // Computes the next state of flags, parameters, read data and duty.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdValid = 1'b0;
    // Control write: start and override follow data, lock only ever sets.
    if (ctrlWr) begin
      // Bits 7 to 4 and the ready bit of the written byte are ignored.
      nxt_st.startFlag = regWrData[fan_ctrl_pkg::START_BIT];
      nxt_st.forceFlag = regWrData[fan_ctrl_pkg::FORCE_BIT];
      // A written zero leaves an engaged lock alone; only power-up reset clears it.
      if (regWrData[fan_ctrl_pkg::LOCK_BIT]) begin
        nxt_st.lockFlag = 1'b1;
      end
    end
    // Control writes never reach the stored bytes, so start leaves them alone.
    // Parameter write lands only while unlocked; otherwise it is dropped.
    if (paramWr && !st_ff.lockFlag) begin
      nxt_st.progRegs[wrIdx] = regWrData;
    end
    // Read answers one cycle later with a valid pulse.
    if (regRdEn) begin
      nxt_st.rdValid = 1'b1;
      if (regAddr == fan_ctrl_pkg::MASTER_CTRL_ADDR) begin
        // Reserved bits read zero; the ready bit is the timer's live level.
        nxt_st.rdData = {4'h0, st_ff.forceFlag, readyFlag, st_ff.lockFlag,
                         st_ff.startFlag};
      end else if (regAddr == fan_ctrl_pkg::CUR_DUTY_ADDR) begin
        // Current duty exactly as it is being driven now.
        nxt_st.rdData = st_ff.duty;
      end else if (fan_ctrl_pkg::in_param_range(regAddr)) begin
        // The stored byte, whichever value the start bit selects.
        nxt_st.rdData = st_ff.progRegs[fan_ctrl_pkg::param_index(regAddr)];
      end else begin
        // Unmapped addresses read zero.
        nxt_st.rdData = fan_ctrl_pkg::READ_ZERO;
      end
    end
    // Working value for the fan logic: defaults until start is set.
    if (paramSelIdx >= 5'(fan_ctrl_pkg::PARAM_COUNT)) begin
      // Indices past the last byte have no register behind them.
      nxt_st.selData = fan_ctrl_pkg::READ_ZERO;
    end else if (st_ff.startFlag) begin
      // Start set: the programmed byte is used.
      nxt_st.selData = st_ff.progRegs[paramSelIdx];
    end else begin
      // Start clear: the built-in default, whatever is stored.
      nxt_st.selData = fan_ctrl_pkg::param_default(paramSelIdx);
    end
    // Duty: override first, then full duty before start, then disable, then normal.
    if (st_ff.forceFlag) begin
      nxt_st.duty = fan_ctrl_pkg::FULL_DUTY;
    end else if (!st_ff.startFlag) begin
      nxt_st.duty = fan_ctrl_pkg::FULL_DUTY;
    end else if (pwmDisabled) begin
      // A disabled channel idles at zero duty once start is set.
      nxt_st.duty = fan_ctrl_pkg::OFF_DUTY;
    end else begin
      // Normal computed duty; it comes back by itself once override clears.
      nxt_st.duty = autoDuty;
    end
  end

  // Registers the state; power-up reset clears flags and loads defaults.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff.startFlag <= fan_ctrl_pkg::MASTER_CTRL_RESET[fan_ctrl_pkg::START_BIT];
      st_ff.lockFlag <= fan_ctrl_pkg::MASTER_CTRL_RESET[fan_ctrl_pkg::LOCK_BIT];
      st_ff.forceFlag <= fan_ctrl_pkg::MASTER_CTRL_RESET[fan_ctrl_pkg::FORCE_BIT];
      // Stored bytes take their built-in defaults at power-up.
      for (int i = 0; i < fan_ctrl_pkg::PARAM_COUNT; i++) begin
        st_ff.progRegs[i] <= fan_ctrl_pkg::param_default(5'(i));
      end
      st_ff.rdData <= fan_ctrl_pkg::READ_ZERO;
      st_ff.rdValid <= 1'b0;
      // Power-up duty is full until start is set.
      st_ff.duty <= fan_ctrl_pkg::FULL_DUTY;
      st_ff.selData <= fan_ctrl_pkg::READ_ZERO;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign regRdData = st_ff.rdData;
  assign regRdValid = st_ff.rdValid;
  assign paramSelData = st_ff.selData;
  assign dutyOut = st_ff.duty;
  assign startActive = st_ff.startFlag;
  assign lockActive = st_ff.lockFlag;
  assign forceFullDuty = st_ff.forceFlag;

  // Checks run on the device clock and pause during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Once set, the lock never falls while power stays up.
  a_lock_stays_set: assert property (st_ff.lockFlag |=> st_ff.lockFlag)
    else $error("Lock flag cleared after being set.");

  // While locked, no parameter byte may change.
  a_locked_params_frozen: assert property (st_ff.lockFlag |=> $stable(st_ff.progRegs))
    else $error("Parameter byte changed while locked.");

  // An unlocked parameter write stores exactly the written byte.
  a_unlocked_write_lands: assert property (
    (paramWr && !st_ff.lockFlag) |=> st_ff.progRegs[$past(wrIdx)] == $past(regWrData))
    else $error("Unlocked parameter write did not land.");

  // Start follows a control write even when locked.
  a_start_writable: assert property (
    ctrlWr |=> st_ff.startFlag == $past(regWrData[fan_ctrl_pkg::START_BIT]))
    else $error("Start bit did not follow a control write.");

  // A control write leaves all stored parameters untouched.
  a_start_keeps_params: assert property (ctrlWr |=> $stable(st_ff.progRegs))
    else $error("Control write altered stored parameters.");

  // With start clear the working value is the built-in default.
  a_default_selected: assert property (
    (!st_ff.startFlag && paramSelIdx < 5'(fan_ctrl_pkg::PARAM_COUNT))
    |=> st_ff.selData == fan_ctrl_pkg::param_default($past(paramSelIdx)))
    else $error("Default not selected while start is clear.");

  // With start set the working value is the programmed byte.
  a_program_selected: assert property (
    (st_ff.startFlag && paramSelIdx < 5'(fan_ctrl_pkg::PARAM_COUNT))
    |=> st_ff.selData == $past(st_ff.progRegs[paramSelIdx]))
    else $error("Programmed value not selected while start is set.");

  // Override forces full duty, even on a disabled channel.
  a_override_full: assert property (
    st_ff.forceFlag |=> st_ff.duty == fan_ctrl_pkg::FULL_DUTY)
    else $error("Override did not force full duty.");

  // After two cycles of override on a disabled channel, duty is full the next cycle.
  a_override_disabled: assert property (
    (st_ff.forceFlag && pwmDisabled) [*2] |=> st_ff.duty == fan_ctrl_pkg::FULL_DUTY)
    else $error("Disabled channel not forced under override.");

  // Before start, duty stays full.
  a_prestart_full: assert property (
    (!st_ff.startFlag && !st_ff.forceFlag) |=> st_ff.duty == fan_ctrl_pkg::FULL_DUTY)
    else $error("Duty not full before start.");

  // With start set, override off and the channel enabled, duty follows the algorithm.
  a_release_normal: assert property (
    (st_ff.startFlag && !st_ff.forceFlag && !pwmDisabled) |=> st_ff.duty == $past(autoDuty))
    else $error("Duty did not return to computed value.");

  // Ready never falls once raised, and a control write cannot move it.
  a_ready_readonly: assert property (readyFlag |=> readyFlag)
    else $error("Ready flag fell.");

  // Control reads return zero in the upper nibble and the start flag in bit 0.
  a_ctrl_read_value: assert property (
    (regRdEn && regAddr == fan_ctrl_pkg::MASTER_CTRL_ADDR && !regWrEn)
    |=> regRdValid && regRdData[7:4] == 4'h0 && regRdData[0] == $past(st_ff.startFlag))
    else $error("Control read returned wrong value.");

  // Ready rises only after the converters are seen healthy.
  a_ready_needs_adc: assert property (
    (!adcOk && !readyFlag) |=> !readyFlag)
    else $error("Ready rose without healthy converters.");

  // Control reads report the override, ready and lock flags as they stood.
  a_ctrl_read_flags: assert property (
    (regRdEn && regAddr == fan_ctrl_pkg::MASTER_CTRL_ADDR)
    |=> regRdData[3:1] == {$past(st_ff.forceFlag), $past(readyFlag), $past(st_ff.lockFlag)})
    else $error("Control read flags wrong.");

  // Writing a one to the lock bit always engages the lock.
  a_lock_write_sets: assert property (
    (ctrlWr && regWrData[fan_ctrl_pkg::LOCK_BIT]) |=> st_ff.lockFlag)
    else $error("Lock write did not engage the lock.");

  // Override follows a control write, locked or not.
  a_force_writable: assert property (
    ctrlWr |=> st_ff.forceFlag == $past(regWrData[fan_ctrl_pkg::FORCE_BIT]))
    else $error("Override bit did not follow a control write.");

  // Parameter reads return the stored byte, never the default selection.
  a_param_read_stored: assert property (
    (regRdEn && fan_ctrl_pkg::in_param_range(regAddr))
    |=> regRdData == $past(st_ff.progRegs[wrIdx]))
    else $error("Parameter read did not return the stored byte.");

  // Duty reads return the duty that was being driven.
  a_duty_read_value: assert property (
    (regRdEn && regAddr == fan_ctrl_pkg::CUR_DUTY_ADDR) |=> regRdData == $past(st_ff.duty))
    else $error("Duty read did not return the driven duty.");

  // Every read strobe is answered by a valid pulse one cycle later.
  a_read_answered: assert property (
    regRdEn |=> regRdValid)
    else $error("Read strobe not answered.");

  // Without override and with start set, a disabled channel runs at zero duty.
  a_disabled_off: assert property (
    (st_ff.startFlag && !st_ff.forceFlag && pwmDisabled)
    |=> st_ff.duty == fan_ctrl_pkg::OFF_DUTY)
    else $error("Disabled channel not off without override.");

  // Main scenarios worth seeing.
  c_lock_set: cover property ($rose(st_ff.lockFlag));
  c_start_set: cover property ($rose(st_ff.startFlag));
  c_override_release: cover property ($fell(st_ff.forceFlag) && st_ff.startFlag);
  c_ready_up: cover property ($rose(readyFlag));
  c_locked_write_dropped: cover property (paramWr && st_ff.lockFlag);

endmodule : fan_ctrl_start_lock_override
`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench for the fan master control register bank.
// Assumes: Reads answer one cycle after the strobe; duty and selection are registered.
// Notes: A behavioural model predicts every read, duty value and parameter selection.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Stimulus driven into the design.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic adcOkAsync = 1'b0;
  logic [4:0] paramSelIdx = 5'h00;
  logic [7:0] autoDuty = 8'h00;
  logic pwmDisabled = 1'b0;
  // Outputs watched by the bench.
  logic [7:0] regRdData;
  logic regRdValid;
  logic [7:0] paramSelData;
  logic [7:0] dutyOut;
  logic startActive;
  logic lockActive;
  logic forceFullDuty;
  // Model state: flags, stored bytes and a queue of expected read data.
  logic mStart = 1'b0;
  logic mLock = 1'b0;
  logic mOvr = 1'b0;
  logic mReady = 1'b0;
  logic [7:0] stored [19];
  logic [7:0] rdQ [$];
  int failures = 0;
  int num_checks = 0;

  // The clock toggles every half period of 25 ns.
  always #25 clk = ~clk;

  fan_ctrl_start_lock_override DUT (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .adcOkAsync(adcOkAsync), .paramSelIdx(paramSelIdx),
    .paramSelData(paramSelData), .autoDuty(autoDuty), .pwmDisabled(pwmDisabled),
    .dutyOut(dutyOut), .startActive(startActive), .lockActive(lockActive),
    .forceFullDuty(forceFullDuty)
  );

  // Built-in default of one parameter byte.
  function automatic logic [7:0] dflt(input int i);
    if (i == 0) begin
      return fan_ctrl_pkg::FAN_CFG_DFLT;
    end else if (i == 3 || i == 4) begin
      return fan_ctrl_pkg::RANGE_DFLT;
    end
    return fan_ctrl_pkg::PARAM_DFLT_OTHER;
  endfunction : dflt

  // Duty the model expects: override, then idle start, then disable, then auto.
  function automatic logic [7:0] mDuty();
    if (mOvr || !mStart) begin
      return 8'hFF;
    end
    return pwmDisabled ? 8'h00 : autoDuty;
  endfunction : mDuty

  // Read value the model expects at one address.
  function automatic logic [7:0] mRead(input logic [7:0] a);
    if (a == 8'h40) begin
      return {4'h0, mOvr, mReady, mLock, mStart};
    end else if (a == 8'h30) begin
      return mDuty();
    end else if (a >= 8'h5C && a <= 8'h6E) begin
      return stored[a - 8'h5C];
    end
    return 8'h00;
  endfunction : mRead

  // Compares one byte and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One write strobe, then the model follows the same write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge clk);
    #2 regWrEn = 1'b0;
    if (a == 8'h40) begin
      mStart = d[0];
      mOvr = d[3];
      mLock = mLock | d[1];
    end else if (a >= 8'h5C && a <= 8'h6E && !mLock) begin
      stored[a - 8'h5C] = d;
    end
  endtask : wr

  // One read strobe; the answer is checked in the cycle it stands.
  task automatic rd(input logic [7:0] a);
    rdQ.push_back(mRead(a));
    @(posedge clk);
    #2 regRdEn = 1'b1;
    regAddr = a;
    @(posedge clk);
    #2 regRdEn = 1'b0;
    chk({7'h00, regRdValid}, 8'h01);
    chk(regRdData, rdQ.pop_front());
  endtask : rd

  // Lets duty settle, then checks it and the flag outputs.
  task automatic chkDuty();
    repeat (2) @(posedge clk);
    #2 chk(dutyOut, mDuty());
    chk({5'h00, forceFullDuty, lockActive, startActive}, {5'h00, mOvr, mLock, mStart});
  endtask : chkDuty

  // Walks every parameter index and checks the working value.
  task automatic chkParams();
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #2 paramSelIdx = i[4:0];
      @(posedge clk);
      #2 chk(paramSelData, (i < 19) ? (mStart ? stored[i] : dflt(i)) : 8'h00);
    end
  endtask : chkParams

  // Writes random bytes to every parameter address.
  task automatic fillParams();
    for (int i = 0; i < 19; i++) begin
      wr(8'h5C + i[7:0], 8'($urandom));
    end
  endtask : fillParams

  // Reads back every parameter address.
  task automatic readParams();
    for (int i = 0; i < 19; i++) begin
      rd(8'h5C + i[7:0]);
    end
  endtask : readParams

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Main sequence.
  initial begin
    void'($urandom(32'h71171558));
    for (int i = 0; i < 19; i++) begin
      stored[i] = dflt(i);
    end
    repeat (12) @(posedge clk);
    #2 rst_n = 1'b1;
    rd(8'h40);
    rd(8'h30);
    chkDuty();
    wr(8'h40, 8'hF4);
    rd(8'h40);
    fillParams();
    chkParams();
    readParams();
    autoDuty = 8'($urandom);
    wr(8'h40, 8'h01);
    chkParams();
    chkDuty();
    rd(8'h30);
    pwmDisabled = 1'b1;
    chkDuty();
    wr(8'h40, 8'h09);
    chkDuty();
    wr(8'h40, 8'h01);
    chkDuty();
    pwmDisabled = 1'b0;
    chkDuty();
    wr(8'h40, 8'h00);
    chkParams();
    readParams();
    wr(8'h40, 8'h02);
    rd(8'h40);
    fillParams();
    readParams();
    wr(8'h40, 8'h01);
    rd(8'h40);
    chkParams();
    wr(8'h40, 8'h08);
    chkDuty();
    rd(8'h41);
    repeat (220) @(posedge clk);
    rd(8'h40);
    adcOkAsync = 1'b1;
    repeat (20) @(posedge clk);
    mReady = 1'b1;
    rd(8'h40);
    // A second power-up reset in mid-run must release the lock and restore defaults.
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2 rst_n = 1'b1;
    mStart = 1'b0;
    mLock = 1'b0;
    mOvr = 1'b0;
    mReady = 1'b0;
    for (int i = 0; i < 19; i++) begin
      stored[i] = dflt(i);
    end
    rd(8'h40);
    chkDuty();
    chkParams();
    fillParams();
    readParams();
    close_out();
  end

  // Watchdog cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
endmodule : tb
`default_nettype wire
